// ### design/swes_top.v
// What this block does
// - Bits 4:2 of the gate select register pick the gate source, and 000 picks none.
// - Gate choices are NAND/NOR of port 2 and port 3 pin groups, optionally with port 0 pins.
// - A wake event rises when the gate output equals the level bit 6.
// - Output pins and pins chosen in the first select register are left out of the gates.
// - Several sources may be active and any one of them wakes the device.
// - Bits 3:0 of the port 3 select register enable port 3 pins 3:0 as wake sources.
// - With no reference, an enabled port 3 pin wakes while it reads zero.
// - Each port 3 read or write after enabling latches the value as the reference.
// - With a reference, an enabled pin wakes while it differs from that reference.
// - The reference status reads 01 after a port read and 10 after a port write.
// - Writing 00 to the reference status restores the compare-with-zero behaviour.
// - Bits 7:4 of the port 3 select register read zero and ignore writes.
// - Both select registers keep their contents across a stop recovery.
// - A qualifying wake event brings the device out of stop mode.
//
// Strobed register access was chosen for this implementation.
`include "swes_regs.vh"

module swes_top (
   // Clock and reset
   input wire ref_clk,
   input wire rst,
   // Register port
   input wire [11:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // Port pins and configuration
   input wire [7:0] port0_pins,
   input wire [7:0] port2_pins,
   input wire [7:0] port3_pins,
   input wire [7:0] port0_is_output,
   input wire [7:0] port2_is_output,
   input wire [7:0] port3_is_output,
   input wire [7:0] wake_pin_select_first,
   // Port 3 data register accesses
   input wire port3_rd,
   input wire port3_wr,
   input wire [7:0] port3_rd_data,
   input wire [7:0] port3_wr_data,
   // Stop mode
   input wire stop_mode,
   input wire other_wake,
   output reg stop_mode_recovery,
   output wire wake_event,
   output wire irq
);
   reg [7:0] gate_sel_reg;
   reg [3:0] p3_sel_reg;
   reg [2:0] irq_stat_reg;
   reg [2:0] irq_en_reg;
   wire gate_hit;
   wire [3:0] p3_hit;
   wire [1:0] ref_stat;

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   // Only rst clears these; a stop recovery leaves them alone
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         gate_sel_reg <= `SWES_RST_GATE_SEL;
         p3_sel_reg <= `SWES_RST_P3_SEL;
         irq_en_reg <= `SWES_RST_IRQ;
      end else if (reg_wr) begin
         case (reg_addr)
            `SWES_OFF_GATE_SEL: gate_sel_reg <= reg_wdata;
            `SWES_OFF_P3_SEL: p3_sel_reg <= reg_wdata[3:0];
            `SWES_OFF_IRQ_EN: irq_en_reg <= reg_wdata[2:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Wake sources
   // ----------------------------------------
   // Port 2 pins taken by the first select register are dropped
   swes_gate_sel u_gate (
      .p0_in(port0_pins),
      .p2_in(port2_pins),
      .p3_in(port3_pins),
      .p0_ign(port0_is_output),
      .p2_ign(port2_is_output | wake_pin_select_first),
      .p3_ign(port3_is_output | {4'h0, p3_sel_reg}),
      .sel(gate_sel_reg[`SWES_GSEL_MSB:`SWES_GSEL_LSB]),
      .level(gate_sel_reg[`SWES_LEVEL_BIT]),
      .hit(gate_hit)
   );

   swes_p3_ref u_p3 (
      .ref_clk(ref_clk),
      .rst(rst),
      .p3_pins(port3_pins[3:0]),
      .enable(p3_sel_reg & ~port3_is_output[3:0]),
      .p3_rd(port3_rd),
      .p3_wr(port3_wr),
      .p3_rd_val(port3_rd_data[3:0]),
      .p3_wr_val(port3_wr_data[3:0]),
      .stat_wr(reg_wr && reg_addr == `SWES_OFF_REF_STAT),
      .stat_val(reg_wdata[3:2]),
      .ref_stat_reg(ref_stat),
      .hit(p3_hit)
   );

   assign wake_event = gate_hit | (|p3_hit) | other_wake;

   // ----------------------------------------
   // Stop mode exit
   // ----------------------------------------
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stop_mode_recovery <= 1'b0;
      end else begin
         stop_mode_recovery <= stop_mode & wake_event;
      end
   end

   // ----------------------------------------
   // Interrupt status
   // ----------------------------------------
   wire [2:0] irq_set = {stop_mode & wake_event, |p3_hit, gate_hit};
   wire [2:0] irq_clr = (reg_wr && reg_addr == `SWES_OFF_IRQ_CLR) ? reg_wdata[2:0] : 3'h0;

   // Set wins over a clear in the same cycle
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq_stat_reg <= `SWES_RST_IRQ;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      end
   end

   assign irq = |(irq_stat_reg & irq_en_reg);

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   // Reserved bits read as zero, which meets the undefined allowance
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `SWES_OFF_GATE_SEL: reg_rdata <= {1'b0, gate_sel_reg[6], 1'b0,
                                              gate_sel_reg[4:2], 2'h0};
            `SWES_OFF_P3_SEL: reg_rdata <= {4'h0, p3_sel_reg};
            `SWES_OFF_REF_STAT: reg_rdata <= {4'h0, ref_stat, 2'h0};
            `SWES_OFF_CTRL: reg_rdata <= {6'h00, stop_mode_recovery, wake_event};
            `SWES_OFF_IRQ_STAT: reg_rdata <= {5'h00, irq_stat_reg};
            `SWES_OFF_IRQ_EN: reg_rdata <= {5'h00, irq_en_reg};
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule // swes_top

// ### design/swes_regs.vh
`ifndef SWES_REGS_VH
`define SWES_REGS_VH
// ----------------------------------------
// Register offsets (12-bit linear address)
// ----------------------------------------
`define SWES_ADDR_W 12
`define SWES_OFF_GATE_SEL 12'hF0D
`define SWES_OFF_P3_SEL 12'hF0E
`define SWES_OFF_REF_STAT 12'hF10
`define SWES_OFF_CTRL 12'hF11
`define SWES_OFF_IRQ_STAT 12'hF12
`define SWES_OFF_IRQ_EN 12'hF13
`define SWES_OFF_IRQ_CLR 12'hF14
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SWES_GSEL_LSB 2
`define SWES_GSEL_MSB 4
`define SWES_LEVEL_BIT 6
`define SWES_P3SEL_MSB 3
// ----------------------------------------
// Reference status codes
// ----------------------------------------
`define SWES_REF_NONE 2'h0
`define SWES_REF_READ 2'h1
`define SWES_REF_WRITE 2'h2
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SWES_RST_GATE_SEL 8'h00
`define SWES_RST_P3_SEL 4'h0
`define SWES_RST_REF 4'h0
`define SWES_RST_IRQ 3'h0
// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define SWES_IRQ_GATE 0
`define SWES_IRQ_P3 1
`define SWES_IRQ_WAKE 2
`endif

// ### design/swes_gate_sel.v
`include "swes_regs.vh"

module swes_gate_sel (
   // Pins and masks
   input wire [7:0] p0_in,
   input wire [7:0] p2_in,
   input wire [7:0] p3_in,
   input wire [7:0] p0_ign,
   input wire [7:0] p2_ign,
   input wire [7:0] p3_ign,
   // Control
   input wire [2:0] sel,
   input wire level,
   // Result
   output reg hit
);
   // ----------------------------------------
   // Masked gates
   // ----------------------------------------
   // Ignored pins become neutral: 1 for NAND terms, 0 for NOR terms
   function and_of;
      input [7:0] v;
      input [7:0] use_m;
      input [7:0] ign;
      begin
         and_of = &(v | ~use_m | ign);
      end
   endfunction

   function or_of;
      input [7:0] v;
      input [7:0] use_m;
      input [7:0] ign;
      begin
         or_of = |(v & use_m & ~ign);
      end
   endfunction

   wire a2 = and_of(p2_in, 8'h0F, p2_ign);
   wire o2 = or_of(p2_in, 8'h0F, p2_ign);
   wire a3 = and_of(p3_in, 8'h0E, p3_ign);
   wire o3 = or_of(p3_in, 8'h0E, p3_ign);
   wire a0 = and_of(p0_in, 8'h81, p0_ign);
   wire o0 = or_of(p0_in, 8'h81, p0_ign);
   wire a2l = and_of(p2_in, 8'h07, p2_ign);
   reg g;

   always @* begin
      g = 1'b0;
      hit = 1'b0;
      case (sel)
         3'h1: g = ~a2;
         3'h2: g = ~o2;
         3'h3: g = ~a3;
         3'h4: g = ~o3;
         3'h5: g = ~(o3 | o0);
         3'h6: g = ~(a3 & a0);
         3'h7: g = ~(a3 & a2l);
         default: g = 1'b0;
      endcase
      if (sel != 3'h0) begin
         hit = (g == level);
      end
   end
endmodule // swes_gate_sel

// ### design/swes_p3_ref.v
`include "swes_regs.vh"

module swes_p3_ref (
   // Clock and reset
   input wire ref_clk,
   input wire rst,
   // Port 3 access
   input wire [3:0] p3_pins,
   input wire [3:0] enable,
   input wire p3_rd,
   input wire p3_wr,
   input wire [3:0] p3_rd_val,
   input wire [3:0] p3_wr_val,
   // Status clear
   input wire stat_wr,
   input wire [1:0] stat_val,
   // Results
   output reg [1:0] ref_stat_reg,
   output wire [3:0] hit
);
   reg [3:0] ref_val_reg;

   // ----------------------------------------
   // Reference latch
   // ----------------------------------------
   // A live access beats a software write to the status field
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ref_val_reg <= `SWES_RST_REF;
         ref_stat_reg <= `SWES_REF_NONE;
      end else if (|enable && p3_wr) begin
         ref_val_reg <= p3_wr_val;
         ref_stat_reg <= `SWES_REF_WRITE;
      end else if (|enable && p3_rd) begin
         ref_val_reg <= p3_rd_val;
         ref_stat_reg <= `SWES_REF_READ;
      end else if (stat_wr && stat_val == `SWES_REF_NONE) begin
         ref_stat_reg <= `SWES_REF_NONE;
      end
   end

   // Default wakes on a low pin: comparing with all ones flags a zero
   wire [3:0] cmp = (ref_stat_reg == `SWES_REF_NONE) ? 4'hF : ref_val_reg;
   assign hit = enable & (p3_pins ^ cmp);
endmodule // swes_p3_ref

// ### test/swes_props.sv
`include "swes_regs.vh"

module swes_props (
   // Clock and reset
   input wire ref_clk,
   input wire rst,
   // Register port
   input wire [11:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata,
   // Wake
   input wire other_wake,
   input wire stop_mode,
   input wire stop_mode_recovery,
   input wire wake_event,
   input wire irq
);
   reg [2:0] gsel_reg;
   reg [3:0] p3s_reg;
   reg [2:0] ien_reg;
   // ------
   // Shadow of written selects and interrupt enables
   // ------
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         gsel_reg <= 3'h0;
         p3s_reg <= 4'h0;
         ien_reg <= 3'h0;
      end else if (reg_wr) begin
         if (reg_addr == `SWES_OFF_GATE_SEL)
            gsel_reg <= reg_wdata[4:2];
         if (reg_addr == `SWES_OFF_P3_SEL)
            p3s_reg <= reg_wdata[3:0];
         if (reg_addr == `SWES_OFF_IRQ_EN)
            ien_reg <= reg_wdata[2:0];
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence rd_s(a);
      reg_rd && reg_addr == a;
   endsequence
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   p3sel_read_a: assert property (rd_s(`SWES_OFF_P3_SEL) |=> reg_rdata == {4'h0, p3s_reg})
      else $error("port 3 select read back wrong");
   ref_field_a: assert property (rd_s(`SWES_OFF_REF_STAT) |=> reg_rdata[3:2] != 2'h3)
      else $error("reference status reads reserved code");
   recovery_a: assert property (stop_mode && wake_event |=> stop_mode_recovery)
      else $error("no recovery after wake in stop");
   no_cause_a: assert property (!stop_mode |=> !stop_mode_recovery)
      else $error("recovery without stop mode");
   any_source_a: assert property (other_wake |-> wake_event)
      else $error("other source did not wake");
   no_source_a: assert property (gsel_reg == 3'h0 && p3s_reg == 4'h0 && !other_wake |-> !wake_event)
      else $error("wake with no source selected");
   irq_mask_a: assert property (ien_reg == 3'h0 |-> !irq)
      else $error("interrupt while all masked");
endmodule // swes_props

bind swes_top swes_props u_props (
   .ref_clk(ref_clk),
   .rst(rst),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .other_wake(other_wake),
   .stop_mode(stop_mode),
   .stop_mode_recovery(stop_mode_recovery),
   .wake_event(wake_event),
   .irq(irq)
);

// ### test/swes_pins.sv
module swes_pins (
   // Clock
   input wire ref_clk,
   // Requested levels
   input wire [7:0] lvl0,
   input wire [7:0] lvl2,
   input wire [7:0] lvl3,
   // Pins
   output reg [7:0] port0_pins,
   output reg [7:0] port2_pins,
   output reg [7:0] port3_pins
);
   // Pins move one edge late, as after a synchroniser
   always @(posedge ref_clk) begin
      port0_pins <= lvl0;
      port2_pins <= lvl2;
      port3_pins <= lvl3;
   end
endmodule // swes_pins

// ### test/swes_top_tb_top.sv
`include "swes_regs.vh"

module swes_top_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   reg ref_clk, rst, reg_wr, reg_rd, port3_rd, port3_wr, stop_mode, other_wake;
   reg [11:0] reg_addr;
   reg [7:0] reg_wdata, port3_wr_data, port0_is_output, port2_is_output, port3_is_output;
   reg [7:0] wake_pin_select_first, l0, l2, l3, a, b, d;
   wire [7:0] reg_rdata, port0_pins, port2_pins, port3_pins;
   wire [7:0] port3_rd_data = port3_wr_data;
   wire stop_mode_recovery, wake_event, irq;
   integer errors, tests_run, cyc, c;

   swes_pins u_pins (.ref_clk(ref_clk), .lvl0(l0), .lvl2(l2), .lvl3(l3),
      .port0_pins(port0_pins), .port2_pins(port2_pins), .port3_pins(port3_pins));
   swes_top u_dut (
      .ref_clk(ref_clk),
      .rst(rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .port0_pins(port0_pins),
      .port2_pins(port2_pins),
      .port3_pins(port3_pins),
      .port0_is_output(port0_is_output),
      .port2_is_output(port2_is_output),
      .port3_is_output(port3_is_output),
      .wake_pin_select_first(wake_pin_select_first),
      .port3_rd(port3_rd),
      .port3_wr(port3_wr),
      .port3_rd_data(port3_rd_data),
      .port3_wr_data(port3_wr_data),
      .stop_mode(stop_mode),
      .other_wake(other_wake),
      .stop_mode_recovery(stop_mode_recovery),
      .wake_event(wake_event),
      .irq(irq)
   );

   initial begin
      ref_clk = 1'h0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // ------
   // Helpers
   // ------
   function gate(input [2:0] s, input [7:0] p0, input [7:0] p2, input [7:0] p3);
      case (s)
         3'h1: gate = ~&p2[3:0];
         3'h2: gate = ~|p2[3:0];
         3'h3: gate = ~&p3[3:1];
         3'h4: gate = ~|p3[3:1];
         3'h5: gate = ~|{p3[3:1], p0[0], p0[7]};
         3'h6: gate = ~&{p3[3:1], p0[0], p0[7]};
         default: gate = ~&{p3[3:1], p2[2:0]};
      endcase
   endfunction
   task cmp8(input [7:0] v, input [7:0] e);
      begin
         tests_run = tests_run + 1;
         if (v !== e) begin
            errors = errors + 1;
            $display("wrong value at %0t: %h not %h", $time, v, e);
         end
      end
   endtask
   task cmp1(input v, input e);
      cmp8({7'h00, v}, {7'h00, e});
   endtask
   task wr(input [11:0] ad, input [7:0] dt);
      begin
         @(posedge ref_clk);
         reg_addr <= ad;
         reg_wdata <= dt;
         reg_wr <= 1'h1;
         @(posedge ref_clk);
         reg_wr <= 1'h0;
      end
   endtask
   task rd(input [11:0] ad, input [7:0] e);
      begin
         @(posedge ref_clk);
         reg_addr <= ad;
         reg_rd <= 1'h1;
         @(posedge ref_clk);
         reg_rd <= 1'h0;
         #1 cmp8(reg_rdata, e);
      end
   endtask
   task pin(input [7:0] p0, input [7:0] p2, input [7:0] p3, input e);
      begin
         @(posedge ref_clk);
         l0 <= p0;
         l2 <= p2;
         l3 <= p3;
         @(posedge ref_clk);
         #1 cmp1(wake_event, e);
      end
   endtask
   task acc(input w, input [7:0] dt);
      begin
         @(posedge ref_clk);
         port3_wr <= w;
         port3_rd <= !w;
         port3_wr_data <= dt;
         @(posedge ref_clk);
         port3_wr <= 1'h0;
         port3_rd <= 1'h0;
      end
   endtask
   task give_verdict;
      begin
         $display("errors %0d of %0d comparisons", errors, tests_run);
         if (errors == 0 && tests_run > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   // Ceiling well above the ~1100 cycles the sequence needs
   always @(posedge ref_clk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         errors = errors + 1;
         give_verdict;
      end
   end
   // ------
   // Sequence
   // ------
   initial begin
      {errors, tests_run, cyc} = 0;
      {rst, reg_wr, reg_rd, port3_rd, port3_wr, stop_mode, other_wake} = 7'h40;
      {reg_addr, reg_wdata, port3_wr_data, port0_is_output, port2_is_output} = 0;
      {port3_is_output, wake_pin_select_first, l0, l2, l3} = 0;
      repeat (5) @(posedge ref_clk);
      rst <= 1'h0;
      rd(`SWES_OFF_P3_SEL, 8'h00);
      rd(12'h123, 8'h00);
      for (c = 0; c < 256; c = c + 1) begin
         a = {c[0], 6'h00, c[0]};
         b = {4'h0, ~c[3:0]};
         d = {4'h0, c[3:0]};
         wr(`SWES_OFF_GATE_SEL, {1'h0, c[4], 1'h0, c[7:5], 2'h0});
         pin(a, b, d, c[7:5] != 3'h0 && gate(c[7:5], a, b, d) == c[4]);
      end
      wr(`SWES_OFF_GATE_SEL, 8'h48);
      pin(8'h00, 8'h01, 8'h00, 1'h0);
      wake_pin_select_first <= 8'h01;
      pin(8'h00, 8'h01, 8'h00, 1'h1);
      wake_pin_select_first <= 8'h00;
      port2_is_output <= 8'h01;
      pin(8'h00, 8'h01, 8'h00, 1'h1);
      port2_is_output <= 8'h00;
      wr(`SWES_OFF_GATE_SEL, 8'h00);
      wr(`SWES_OFF_P3_SEL, 8'hF1);
      pin(8'h00, 8'h00, 8'h00, 1'h1);
      pin(8'h00, 8'h00, 8'h01, 1'h0);
      acc(1'h1, 8'h00);
      rd(`SWES_OFF_REF_STAT, 8'h08);
      pin(8'h00, 8'h00, 8'h01, 1'h1);
      acc(1'h0, 8'h01);
      rd(`SWES_OFF_REF_STAT, 8'h04);
      pin(8'h00, 8'h00, 8'h01, 1'h0);
      pin(8'h00, 8'h00, 8'h00, 1'h1);
      wr(`SWES_OFF_REF_STAT, 8'h00);
      pin(8'h00, 8'h00, 8'h01, 1'h0);
      pin(8'h00, 8'h00, 8'h00, 1'h1);
      stop_mode <= 1'h1;
      @(posedge ref_clk);
      #1 cmp1(stop_mode_recovery, 1'h1);
      rd(`SWES_OFF_CTRL, 8'h03);
      stop_mode <= 1'h0;
      rd(`SWES_OFF_P3_SEL, 8'h01);
      rd(`SWES_OFF_IRQ_STAT, 8'h07);
      other_wake <= 1'h1;
      pin(8'h00, 8'h00, 8'h01, 1'h1);
      other_wake <= 1'h0;
      wr(`SWES_OFF_IRQ_CLR, 8'h07);
      rd(`SWES_OFF_IRQ_STAT, 8'h00);
      pin(8'h00, 8'h00, 8'h00, 1'h1);
      pin(8'h00, 8'h00, 8'h01, 1'h0);
      rd(`SWES_OFF_IRQ_STAT, 8'h02);
      wr(`SWES_OFF_IRQ_EN, 8'h02);
      #1 cmp1(irq, 1'h1);
      wr(`SWES_OFF_IRQ_EN, 8'h00);
      #1 cmp1(irq, 1'h0);
      wr(`SWES_OFF_IRQ_EN, 8'h02);
      wr(`SWES_OFF_IRQ_CLR, 8'h07);
      #1 cmp1(irq, 1'h0);
      give_verdict;
   end
endmodule // swes_top_tb_top
